// ---- rtl/sam_pkg.sv ----
package sam_pkg;
  // register byte addresses
  localparam logic [31:0] GRP_BASE   = 32'h0000_0000;
  localparam logic [31:0] REC_ERR    = 32'h0000_0020;
  localparam logic [31:0] REC_STS    = 32'h0000_0024;
  localparam logic [31:0] ACT_EN     = 32'h0000_0028;
  localparam logic [31:0] ACT_STS    = 32'h0000_002c;
  localparam logic [31:0] IRQ_STS    = 32'h0000_0030;
  localparam logic [31:0] IRQ_MASK   = 32'h0000_0034;
  localparam logic [31:0] FAULT_ADDR = 32'hf006_38f0;
  localparam logic [31:0] ECC_ADDR   = 32'hf006_3810;
  // group index field of a group address
  localparam int          GRP_LSB    = 2;
  localparam int          GRP_MSB    = 4;
  // reset values
  localparam logic [31:0] GRP_RST    = 32'h0000_0000;
  localparam logic [31:0] GRP7_RST   = 32'h0000_0003;
  localparam logic [31:0] REC_RST    = 32'h0000_0000;
  localparam logic [15:0] FAULT_RST  = 16'h0001;
  localparam logic [15:0] ECC_RST    = 16'h0001;
  localparam logic [7:0]  ACTEN_RST  = 8'h00;
  localparam logic [9:0]  IRQ_RST    = 10'h000;
  // interrupt status bit positions
  localparam int          IRQ_REC    = 8;
  localparam int          IRQ_ACT    = 9;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0][31:0] alarm;
    logic [31:0]      rec_err;
    logic [31:0]      rec_sts;
    logic [15:0]      fault;
    logic [15:0]      ecc;
  } event_in_t;

  typedef struct packed {
    logic [7:0][31:0] alarm;
    logic [31:0]      rec_err;
    logic [31:0]      rec_sts;
    logic [15:0]      fault;
    logic [15:0]      ecc;
    logic [7:0]       act_en;
    logic             act;
    logic [9:0]       irq_sts;
    logic [9:0]       irq_mask;
    logic [31:0]      rdata;
  } state_t;
endpackage

// ---- rtl/safety_alarm_unit.sv ----
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// - masked read-modify-write acts as a whole-word write, touching every bit
// - alarm group flags clear by writing one; 0x4 clears only bit 2
// - recovery flags clear by writing zero; 0xfffffffb clears only bit 2
// - alarm action follows incoming alarms, not flags software may clear
// - group seven alarms 1 and 0 are set after every reset
module safety_alarm_unit (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  // register port
  input  wire sam_pkg::bus_req_t  req_i,
  output logic [31:0]             rdata_o,
  // alarm and flag events
  input  wire sam_pkg::event_in_t ev_i,
  // reaction and interrupt
  output logic                    action_o,
  output logic                    irq_o
);

  sam_pkg::state_t q_reg;
  sam_pkg::state_t q_next;
  logic [9:0]      irq_ev;
  logic            act_trig;
  logic            grp_hit;
  logic [2:0]      grp_idx;
  logic [31:0]     set_vec;
  logic            fault_lvl;
  logic            ecc_lvl;
  localparam int   GRP_MSB_P1 = sam_pkg::GRP_MSB + 1;

  always_comb begin
    q_next   = q_reg;
    irq_ev   = '0;
    grp_hit  = (req_i.addr[31:GRP_MSB_P1] == '0);
    grp_idx  = req_i.addr[sam_pkg::GRP_MSB:sam_pkg::GRP_LSB];
    set_vec  = '0;
    // controller state holds its alarms up while not cleared
    fault_lvl = |q_reg.fault;
    ecc_lvl   = |q_reg.ecc;
    act_trig  = 1'b0;

    for (int g = 0; g < 8; g++) begin
      set_vec = ev_i.alarm[g];
      if (g == 7) begin
        set_vec[0] = set_vec[0] | fault_lvl;
        set_vec[1] = set_vec[1] | ecc_lvl;
      end
      // whole word applied at once, hardware set wins
      if (req_i.wr && grp_hit && grp_idx == 3'(g)) begin
        q_next.alarm[g] = (q_reg.alarm[g] & ~req_i.wdata) | set_vec;
      end else begin
        q_next.alarm[g] = q_reg.alarm[g] | set_vec;
      end
      irq_ev[g] = |ev_i.alarm[g];
      if (q_reg.act_en[g] && (|ev_i.alarm[g])) begin
        act_trig = 1'b1;
      end
    end

    // recovery flags: written zeros clear, set wins
    if (req_i.wr && req_i.addr == sam_pkg::REC_ERR) begin
      q_next.rec_err = (q_reg.rec_err & req_i.wdata) | ev_i.rec_err;
    end else begin
      q_next.rec_err = q_reg.rec_err | ev_i.rec_err;
    end
    if (req_i.wr && req_i.addr == sam_pkg::REC_STS) begin
      q_next.rec_sts = (q_reg.rec_sts & req_i.wdata) | ev_i.rec_sts;
    end else begin
      q_next.rec_sts = q_reg.rec_sts | ev_i.rec_sts;
    end
    irq_ev[sam_pkg::IRQ_REC] = |ev_i.rec_err;

    // test controller state: a write stores the low half, zero clears it
    if (req_i.wr && req_i.addr == sam_pkg::FAULT_ADDR) begin
      q_next.fault = req_i.wdata[15:0] | ev_i.fault;
    end else begin
      q_next.fault = q_reg.fault | ev_i.fault;
    end
    if (req_i.wr && req_i.addr == sam_pkg::ECC_ADDR) begin
      q_next.ecc = req_i.wdata[15:0] | ev_i.ecc;
    end else begin
      q_next.ecc = q_reg.ecc | ev_i.ecc;
    end

    // action latch is independent of the flag registers
    if (act_trig) begin
      q_next.act = 1'b1;
    end
    irq_ev[sam_pkg::IRQ_ACT] = act_trig && !q_reg.act;

    if (req_i.wr && req_i.addr == sam_pkg::ACT_EN) begin
      q_next.act_en = req_i.wdata[7:0];
    end
    if (req_i.wr && req_i.addr == sam_pkg::IRQ_MASK) begin
      q_next.irq_mask = req_i.wdata[9:0];
    end

    // read data, one cycle late; interrupt status clears on read
    q_next.rdata   = '0;
    q_next.irq_sts = q_reg.irq_sts | irq_ev;
    if (req_i.rd) begin
      if (grp_hit) begin
        q_next.rdata = q_reg.alarm[grp_idx];
      end else begin
        unique case (req_i.addr)
          sam_pkg::REC_ERR:    q_next.rdata = q_reg.rec_err;
          sam_pkg::REC_STS:    q_next.rdata = q_reg.rec_sts;
          sam_pkg::ACT_EN:     q_next.rdata = {24'h0, q_reg.act_en};
          sam_pkg::ACT_STS:    q_next.rdata = {31'h0, q_reg.act};
          sam_pkg::IRQ_MASK:   q_next.rdata = {22'h0, q_reg.irq_mask};
          sam_pkg::FAULT_ADDR: q_next.rdata = {16'h0, q_reg.fault};
          sam_pkg::ECC_ADDR:   q_next.rdata = {16'h0, q_reg.ecc};
          sam_pkg::IRQ_STS: begin
            q_next.rdata   = {22'h0, q_reg.irq_sts};
            q_next.irq_sts = irq_ev;
          end
          default:             q_next.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int g = 0; g < 7; g++) begin
        q_reg.alarm[g] <= sam_pkg::GRP_RST;
      end
      q_reg.alarm[7]  <= sam_pkg::GRP7_RST;
      q_reg.rec_err   <= sam_pkg::REC_RST;
      q_reg.rec_sts   <= sam_pkg::REC_RST;
      q_reg.fault     <= sam_pkg::FAULT_RST;
      q_reg.ecc       <= sam_pkg::ECC_RST;
      q_reg.act_en    <= sam_pkg::ACTEN_RST;
      q_reg.act       <= 1'b0;
      q_reg.irq_sts   <= sam_pkg::IRQ_RST;
      q_reg.irq_mask  <= sam_pkg::IRQ_RST;
      q_reg.rdata     <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign rdata_o  = q_reg.rdata;
  assign action_o = q_reg.act;
  assign irq_o    = |(q_reg.irq_sts & q_reg.irq_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_grp_w1c;
    req_i.wr && req_i.addr == sam_pkg::GRP_BASE && req_i.wdata == 32'h0000_0004 && ev_i.alarm[0] == '0
      |=> q_reg.alarm[0] == ($past(q_reg.alarm[0]) & 32'hffff_fffb);
  endproperty
  a_grp_w1c: assert property (p_grp_w1c) else $error("group flag write-one clear wrong");

  property p_rec_w0c;
    req_i.wr && req_i.addr == sam_pkg::REC_ERR && req_i.wdata == 32'hffff_fffb && ev_i.rec_err == '0
      |=> q_reg.rec_err == ($past(q_reg.rec_err) & 32'hffff_fffb);
  endproperty
  a_rec_w0c: assert property (p_rec_w0c) else $error("recovery flag write-zero clear wrong");

  property p_full_word;
    req_i.wr && req_i.addr == sam_pkg::REC_STS && ev_i.rec_sts == '0
      |=> q_reg.rec_sts == ($past(q_reg.rec_sts) & $past(req_i.wdata));
  endproperty
  a_full_word: assert property (p_full_word) else $error("word write not applied whole");

  property p_rmw_whole;
    req_i.wr && req_i.addr == sam_pkg::GRP_BASE && ev_i.alarm[0] == '0
      |=> q_reg.alarm[0] == ($past(q_reg.alarm[0]) & ~$past(req_i.wdata));
  endproperty
  a_rmw_whole: assert property (p_rmw_whole) else $error("group write touched wrong bits");

  property p_reset_alarm;
    $rose(resetn_i) |-> q_reg.alarm[7][1:0] == 2'b11 && q_reg.fault != '0;
  endproperty
  a_reset_alarm: assert property (p_reset_alarm) else $error("group seven alarms not set after reset");

  property p_fault_hold;
    (|q_reg.fault) |=> q_reg.alarm[7][0];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("group seven alarm 0 cleared early");

  property p_ecc_hold;
    (|q_reg.ecc) |=> q_reg.alarm[7][1];
  endproperty
  a_ecc_hold: assert property (p_ecc_hold) else $error("group seven alarm 1 cleared early");

  property p_action;
    act_trig |=> action_o ##1 action_o;
  endproperty
  a_action: assert property (p_action) else $error("alarm action lost");

  property p_fault_clr;
    req_i.wr && req_i.addr == sam_pkg::FAULT_ADDR && req_i.wdata[15:0] == 16'h0000 && ev_i.fault == '0
      |=> q_reg.fault == 16'h0000;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault status not cleared");

  property p_ecc_clr;
    req_i.wr && req_i.addr == sam_pkg::ECC_ADDR && req_i.wdata[15:0] == 16'h0000 && ev_i.ecc == '0
      |=> q_reg.ecc == 16'h0000;
  endproperty
  a_ecc_clr: assert property (p_ecc_clr) else $error("ECC detect not cleared");

  property p_rdata;
    req_i.rd && req_i.addr == sam_pkg::REC_ERR |=> rdata_o == $past(q_reg.rec_err) ##1 rdata_o == '0 || $past(req_i.rd);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data late or wrong");

  // flag register checks
  property p_rec_sts_w0c;
    req_i.wr && req_i.addr == sam_pkg::REC_STS && req_i.wdata == 32'hffff_fffb && ev_i.rec_sts == '0
      |=> q_reg.rec_sts == ($past(q_reg.rec_sts) & 32'hffff_fffb);
  endproperty
  a_rec_sts_w0c: assert property (p_rec_sts_w0c) else $error("recovery status write-zero clear wrong");

  property p_grp_set_wins;
    req_i.wr && grp_hit && grp_idx == 3'h0
      |=> (q_reg.alarm[0] & $past(ev_i.alarm[0])) == $past(ev_i.alarm[0]);
  endproperty
  a_grp_set_wins: assert property (p_grp_set_wins) else $error("group event lost to a clear");

  property p_rec_set_wins;
    req_i.wr && req_i.addr == sam_pkg::REC_ERR
      |=> (q_reg.rec_err & $past(ev_i.rec_err)) == $past(ev_i.rec_err);
  endproperty
  a_rec_set_wins: assert property (p_rec_set_wins) else $error("recovery event lost to a clear");

  property p_rec_idle;
    !(req_i.wr && req_i.addr == sam_pkg::REC_ERR) && ev_i.rec_err == '0
      |=> q_reg.rec_err == $past(q_reg.rec_err);
  endproperty
  a_rec_idle: assert property (p_rec_idle) else $error("recovery flags changed without cause");

  property p_grp_idle;
    !(req_i.wr && grp_hit && grp_idx == 3'h0) && ev_i.alarm[0] == '0
      |=> q_reg.alarm[0] == $past(q_reg.alarm[0]);
  endproperty
  a_grp_idle: assert property (p_grp_idle) else $error("group flags changed without cause");

  property p_grp7_w1c;
    req_i.wr && grp_hit && grp_idx == 3'h7 && q_reg.fault == '0 && q_reg.ecc == '0 && ev_i.alarm[7] == '0
      |=> q_reg.alarm[7] == ($past(q_reg.alarm[7]) & ~$past(req_i.wdata));
  endproperty
  a_grp7_w1c: assert property (p_grp7_w1c) else $error("group seven clear wrong once released");

  // controller, action, interrupt and read data checks
  property p_action_sticky;
    action_o |=> action_o;
  endproperty
  a_action_sticky: assert property (p_action_sticky) else $error("alarm action dropped");

  property p_action_enable;
    q_reg.act_en == '0 && !action_o |=> !action_o;
  endproperty
  a_action_enable: assert property (p_action_enable) else $error("alarm action without enable");

  property p_act_en_write;
    req_i.wr && req_i.addr == sam_pkg::ACT_EN |=> q_reg.act_en == $past(req_i.wdata[7:0]);
  endproperty
  a_act_en_write: assert property (p_act_en_write) else $error("action enable not stored");

  property p_irq_set;
    (|ev_i.alarm[0]) |=> q_reg.irq_sts[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("group event not flagged");

  property p_irq_rd_clr;
    req_i.rd && req_i.addr == sam_pkg::IRQ_STS && ev_i.alarm == '0 && ev_i.rec_err == '0 && !act_trig
      |=> q_reg.irq_sts == '0;
  endproperty
  a_irq_rd_clr: assert property (p_irq_rd_clr) else $error("interrupt status not cleared by read");

  property p_rdata_idle;
    !req_i.rd |=> rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_grp_read;
    req_i.rd && grp_hit |=> rdata_o == $past(q_reg.alarm[grp_idx]);
  endproperty
  a_grp_read: assert property (p_grp_read) else $error("group read data wrong");

  property p_fault_write;
    req_i.wr && req_i.addr == sam_pkg::FAULT_ADDR && ev_i.fault == '0
      |=> q_reg.fault == $past(req_i.wdata[15:0]);
  endproperty
  a_fault_write: assert property (p_fault_write) else $error("fault status write not stored");

  property p_ecc_write;
    req_i.wr && req_i.addr == sam_pkg::ECC_ADDR && ev_i.ecc == '0
      |=> q_reg.ecc == $past(req_i.wdata[15:0]);
  endproperty
  a_ecc_write: assert property (p_ecc_write) else $error("ECC detect write not stored");

  c_clear_all: cover property (req_i.wr && grp_hit && grp_idx == 3'h7 && q_reg.fault == '0 && q_reg.ecc == '0
                               ##1 q_reg.alarm[7][1:0] == 2'b00);
  c_rmw_clear: cover property (req_i.wr && grp_hit && req_i.wdata == 32'hffff_00f0);
  c_reset_alarm: cover property ($rose(resetn_i) ##0 q_reg.alarm[7][1:0] == 2'b11);
  c_action: cover property (act_trig ##1 action_o);
  c_irq: cover property (irq_o ##1 req_i.rd && req_i.addr == sam_pkg::IRQ_STS);

endmodule // safety_alarm_unit

// ---- verification/test_safety_alarm_unit.sv ----
`timescale 1ns/1ns
module test_safety_alarm_unit;
  logic                clk;
  logic                resetn;
  sam_pkg::bus_req_t   req;
  sam_pkg::event_in_t  ev;
  logic [31:0]         rdata;
  logic                action;
  logic                irq;
  int                  err_count;
  int                  total_checks;

  safety_alarm_unit safety_alarm_unit_i (
    .clk_i    (clk),
    .resetn_i (resetn),
    .req_i    (req),
    .rdata_o  (rdata),
    .ev_i     (ev),
    .action_o (action),
    .irq_o    (irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test;
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic pulse_alarm(input int g, input logic [31:0] v);
    @(posedge clk);
    ev.alarm[g] <= v;
    @(posedge clk);
    ev.alarm[g] <= 32'h0000_0000;
  endtask

  task automatic reset_and_group7;
    rd_chk(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0003);
    rd_chk(sam_pkg::GRP_BASE, 32'h0000_0000);
    wr(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0003);
    rd_chk(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0003);
    wr(sam_pkg::FAULT_ADDR, 32'h0000_0000);
    rd_chk(sam_pkg::FAULT_ADDR, 32'h0000_0000);
    wr(sam_pkg::ECC_ADDR, 32'h0000_0000);
    rd_chk(sam_pkg::ECC_ADDR, 32'h0000_0000);
    wr(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0003);
    rd_chk(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0000);
    rd_chk(32'h0000_0100, 32'h0000_0000);
  endtask

  task automatic flag_clears;
    pulse_alarm(0, 32'hffff_ffff);
    wr(sam_pkg::GRP_BASE, 32'h0000_0004);
    rd_chk(sam_pkg::GRP_BASE, 32'hffff_fffb);
    @(posedge clk);
    ev.rec_err <= 32'hffff_ffff;
    ev.rec_sts <= 32'hffff_ffff;
    @(posedge clk);
    ev.rec_err <= 32'h0000_0000;
    ev.rec_sts <= 32'h0000_0000;
    wr(sam_pkg::REC_ERR, 32'hffff_fffb);
    wr(sam_pkg::REC_STS, 32'hffff_fffb);
    rd_chk(sam_pkg::REC_ERR, 32'hffff_fffb);
    rd_chk(sam_pkg::REC_STS, 32'hffff_fffb);
    // masked update lands as the whole written word
    wr(sam_pkg::GRP_BASE, 32'hffff_00f0);
    rd_chk(sam_pkg::GRP_BASE, 32'h0000_ff0b);
  endtask

  task automatic irq_path;
    rd_chk(sam_pkg::IRQ_STS, 32'h0000_0101);
    rd_chk(sam_pkg::IRQ_STS, 32'h0000_0000);
    wr(sam_pkg::IRQ_MASK, 32'h0000_0001);
    rd_chk(sam_pkg::IRQ_MASK, 32'h0000_0001);
    pulse_alarm(1, 32'h0000_0001);
    #1 chk_bit(irq, 1'b0);
    pulse_alarm(0, 32'h0000_0001);
    #1 chk_bit(irq, 1'b1);
    rd_chk(sam_pkg::IRQ_STS, 32'h0000_0003);
    chk_bit(irq, 1'b0);
  endtask

  task automatic action_sticky;
    wr(sam_pkg::ACT_EN, 32'h0000_0001);
    #1 chk_bit(action, 1'b0);
    rd_chk(sam_pkg::ACT_EN, 32'h0000_0001);
    pulse_alarm(0, 32'h0000_0010);
    #1 chk_bit(action, 1'b1);
    wr(sam_pkg::GRP_BASE, 32'hffff_ffff);
    rd_chk(sam_pkg::GRP_BASE, 32'h0000_0000);
    // status register is read-only, the write must be ignored
    wr(sam_pkg::ACT_STS, 32'h0000_0000);
    rd_chk(sam_pkg::ACT_STS, 32'h0000_0001);
    chk_bit(action, 1'b1);
  endtask

  // system reset in mid-run brings the group seven alarms back
  task automatic mid_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1 chk_bit(action, 1'b0);
    rd_chk(sam_pkg::GRP_BASE + 32'h0000_001c, 32'h0000_0003);
    rd_chk(sam_pkg::ECC_ADDR, 32'h0000_0001);
  endtask

  initial begin
    err_count    = 0;
    total_checks = 0;
    resetn       = 1'b0;
    req          = '0;
    ev           = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    #1 chk(rdata, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    reset_and_group7;
    flag_clears;
    irq_path;
    action_sticky;
    mid_reset;
    end_of_test;
  end

  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
endmodule // test_safety_alarm_unit
